// >>> chain_gateway_model.sv
// gateway-side model of the serial diagnostic chain
`timescale 1ns/100ps
`default_nettype none
module chain_gateway_model #(
	parameter int unsigned CHAIN_POS = 1 // units ahead of gateway
) (
	input wire logic clk, // system clock
	output logic sdi, // into the unit
	output logic sent_ff // bit driven one cycle earlier
);
	logic [7:0] pat_ff;
	initial begin
		pat_ff = 8'ha5;
		sdi = 1'b0;
		sent_ff = 1'b0;
		if (CHAIN_POS < 1 || CHAIN_POS > 31) begin
			$display("Error chain length %0d", CHAIN_POS);
		end
	end
	// pattern changes nearly every cycle, no stale level
	always @(posedge clk) begin
		pat_ff <= {pat_ff[6:0], pat_ff[7]};
		sdi <= pat_ff[0];
		sent_ff <= sdi;
	end
endmodule : chain_gateway_model
`default_nettype wire

// >>> diag_timebase.sv
// divider producing flash ticks and square waves
`timescale 1ns/100ps
`default_nettype none
module diag_timebase
	import sensor_diag_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYCLES
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset, low
	output logic tick, // one pulse per flash tick
	output logic sec_tick, // one pulse per second
	output logic fast_ff, // 5 hz square
	output logic slow_ff, // 1 hz square
	output logic phase_ff // toggles every second
);
	if (TICK_CYC < 2) begin : g_bad_tick
		$error("TICK_CYC must be at least 2");
	end
	logic [31:0] div_ff;
	logic [3:0] sub_ff;
	logic [3:0] half_ff;
	assign tick = (div_ff == TICK_CYC - 1);
	assign sec_tick = tick && (sub_ff == 4'(TICKS_PER_SEC - 1));
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_ff <= 32'h0;
			sub_ff <= 4'h0;
			half_ff <= 4'h0;
			fast_ff <= 1'b0;
			slow_ff <= 1'b0;
			phase_ff <= 1'b0;
		end else begin
			div_ff <= tick ? 32'h0 : div_ff + 32'h1;
			if (tick) begin
				fast_ff <= !fast_ff;
				sub_ff <= sec_tick ? 4'h0 : sub_ff + 4'h1;
				half_ff <= (half_ff == 4'(SLOW_HALF_TICKS - 1)) ?
					4'h0 : half_ff + 4'h1;
				if (half_ff == 4'(SLOW_HALF_TICKS - 1))
					slow_ff <= !slow_ff;
				if (sec_tick)
					phase_ff <= !phase_ff;
			end
		end
	end
endmodule : diag_timebase
`default_nettype wire

// >>> flash_code_gen.sv
// red indicator pulse-count generator
`timescale 1ns/100ps
`default_nettype none
module flash_code_gen
	import sensor_diag_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset, low
	input wire logic tick, // flash tick enable
	input wire logic [2:0] code, // pulses per burst, 0 steady
	output logic red_ff // red indicator drive
);
	logic [4:0] step_ff;
	wire [4:0] burst_len = {1'b0, code, 1'b0};
	wire [4:0] last_step = 5'(burst_len + 5'(FLASH_PAUSE_TICKS) - 5'd1);
	wire nxt_red = (code == 3'h0) ||
		((step_ff < burst_len) && !step_ff[0]);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_ff <= 5'h0;
			red_ff <= 1'b0;
		end else begin
			if (tick)
				step_ff <= (step_ff >= last_step) ? 5'h0 : step_ff + 5'h1;
			red_ff <= nxt_red;
		end
	end
endmodule : flash_code_gen
`default_nettype wire

// >>> safety_sensor_diag.sv
// diagnostic and status logic of the contactless safety sensor
// ------------------------------------------------------------
// Summary of operation
// RULE_01: internal error disables outputs; guard cycle clears
// RULE_02: warning drops diagnostic output, outputs stay on
// RULE_03: warning clears itself when cause gone
// RULE_04: warning held thirty minutes trips outputs, red
// RULE_05: idle: green only, all outputs inactive
// RULE_06: active: steady yellow, diagnostic and outputs on
// RULE_07: marginal zone: yellow 1 hz, diagnostic pulsed
// RULE_08: feedback wait: green, yellow 1 hz, outputs off
// RULE_09: marginal feedback wait: yellow alternates 1/5 hz
// RULE_10: error: outputs off, red flashes or steady
// RULE_11: teaching: red steady, yellow flashes, outputs off
// RULE_12: ten minute protection after reteach, green flashes
// RULE_13: missing input: green 1 hz, outputs off
// RULE_14: serial variant: serial in and out chained
// RULE_15: chain holds at most thirty-one sensors
// RULE_16: serial link failure freezes safety outputs
// RULE_17: response bits 0,1,4,5 report state
// RULE_18: response bits 3,6,7 report feedback, warning, error
// RULE_19: serial error clears on request bit falling
// RULE_20: output faults clear only at next release
// RULE_21: red pulse count names the error cause
// RULE_22: actuator leaving zone disables outputs at once
// RULE_23: diagnostic pulse period is two flash ticks
// ------------------------------------------------------------
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module safety_sensor_diag
	import sensor_diag_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYCLES,
	parameter int unsigned WARN_S = WARN_DELAY_S,
	parameter int unsigned PROT_S = PROTECT_S
) (
	input wire logic REF_CLK, // 125 mhz clock
	input wire logic RESET_N, // async reset, low
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb access phase
	input wire logic PWRITE, // apb write
	input wire logic [7:0] PADDR, // apb byte address
	input wire logic [31:0] PWDATA, // apb write data
	output logic [31:0] PRDATA, // apb read data
	output logic PREADY, // apb ready
	output logic PSLVERR, // apb error
	input wire logic SAFETY_INPUT_ONE, // safety input one live
	input wire logic SAFETY_INPUT_TWO, // safety input two live
	input wire logic ACTUATOR_IN_RANGE, // actuator detected
	input wire logic ACTUATOR_MARGINAL, // actuator in limit area
	input wire logic FEEDBACK_IN, // feedback circuit closed
	input wire logic INTERNAL_FAULT, // internal safety fault
	input wire logic [5:0] FAULT_CAUSE, // error causes
	input wire logic [2:0] WARN_CAUSE, // warning causes
	input wire logic TEACH_ACTIVE, // actuator teaching in progress
	input wire logic COMM_FAIL, // gateway link lost
	input wire logic SERIAL_DIAG_IN, // serial chain input
	output logic SERIAL_DIAG_OUT, // serial chain output
	output logic DIAG_OUT, // plain diagnostic output
	output logic SAFETY_OUTPUT_ONE, // safety output one
	output logic SAFETY_OUTPUT_TWO, // safety output two
	output logic LED_GREEN, // green indicator
	output logic LED_RED, // red indicator
	output logic LED_YELLOW // yellow indicator
);
	if (WARN_S < 1 || WARN_S > 4095 || PROT_S < 1 || PROT_S > 4095)
	begin : g_bad_time
		$error("WARN_S and PROT_S must lie in 1..4095");
	end
	// ------------------------------------------------------------
	// state and registers
	// ------------------------------------------------------------
	state_type state_ff;
	state_type nxt_state;
	logic [1:0] ctrl_ff;
	logic [7:0] request_ff;
	logic req_prev_ff;
	logic fb_prev_ff;
	logic teach_prev_ff;
	logic [11:0] warn_sec_ff;
	logic warn_trip_ff;
	logic [11:0] prot_sec_ff;
	logic guard_open_ff;
	logic [5:0] cause_ff;
	logic [5:0] out_fault_ff;
	logic safe_ff;
	logic diag_ff;
	logic sdo_ff;
	logic [7:0] resp_ff;
	led_type led_ff;
	led_type nxt_led;
	logic nxt_diag;
	logic [2:0] flash_code;
	// ------------------------------------------------------------
	// time base and flash code
	// ------------------------------------------------------------
	logic tick;
	logic sec_tick;
	logic fast_sq;
	logic slow_sq;
	logic phase_sq;
	logic red_code;
	diag_timebase #(
		.TICK_CYC(TICK_CYC)
	) u_timebase (
		.clk(REF_CLK),
		.rst_n(RESET_N),
		.tick(tick),
		.sec_tick(sec_tick),
		.fast_ff(fast_sq),
		.slow_ff(slow_sq),
		.phase_ff(phase_sq)
	);
	flash_code_gen u_flash (
		.clk(REF_CLK),
		.rst_n(RESET_N),
		.tick(tick),
		.code(flash_code),
		.red_ff(red_code)
	);
	// ------------------------------------------------------------
	// decoded conditions
	// ------------------------------------------------------------
	wire serial_var = ctrl_ff[CTRL_SERIAL_BIT];
	wire edge_var = ctrl_ff[CTRL_EDGE_BIT];
	wire inputs_ok = SAFETY_INPUT_ONE && SAFETY_INPUT_TWO;
	wire act = ACTUATOR_IN_RANGE;
	wire marg = ACTUATOR_IN_RANGE && ACTUATOR_MARGINAL;
	wire warn_now = |WARN_CAUSE;
	wire hold = serial_var && COMM_FAIL;
	wire fb_release = edge_var ? (fb_prev_ff && !FEEDBACK_IN) // RULE_08
		: FEEDBACK_IN;
	wire cause_now = INTERNAL_FAULT || (|FAULT_CAUSE) || warn_trip_ff;
	wire req_fall = req_prev_ff && !request_ff[REQ_RESET_BIT];
	wire serial_ack = req_fall || !act; // RULE_19
	wire plain_ack = guard_open_ff && act; // RULE_01
	wire err_clear = !cause_now && (serial_var ? serial_ack : plain_ack);
	wire warn_hit = warn_now && sec_tick &&
		(warn_sec_ff == 12'(WARN_S - 1));
	wire prot_done = sec_tick && (prot_sec_ff == 12'(PROT_S - 1));
	wire teach_fell = teach_prev_ff && !TEACH_ACTIVE;
	wire yellow_alt = phase_sq ? fast_sq : slow_sq; // RULE_09
	wire nxt_safe = (nxt_state == ST_ACTIVE); // RULE_22
	wire released = nxt_safe && !safe_ff && !hold;
	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_ERROR: begin
				if (err_clear)
					nxt_state = ST_IDLE;
			end
			ST_TEACH: begin
				if (teach_fell)
					nxt_state = ST_PROTECT; // RULE_12
			end
			ST_PROTECT: begin
				if (prot_done)
					nxt_state = ST_IDLE;
			end
			ST_IDLE, ST_NO_INPUT, ST_WAIT_FB, ST_ACTIVE: begin
				if (!inputs_ok)
					nxt_state = ST_NO_INPUT; // RULE_13
				else if (!act)
					nxt_state = ST_IDLE; // RULE_22
				else if (state_ff == ST_ACTIVE || fb_release)
					nxt_state = ST_ACTIVE;
				else
					nxt_state = ST_WAIT_FB; // RULE_08
			end
			default: nxt_state = ST_IDLE;
		endcase
		if (cause_now && state_ff != ST_ERROR)
			nxt_state = ST_ERROR; // RULE_01
		else if (TEACH_ACTIVE && state_ff != ST_ERROR)
			nxt_state = ST_TEACH; // RULE_11
	end
	// ------------------------------------------------------------
	// indicators and diagnostic output
	// ------------------------------------------------------------
	always_comb begin
		nxt_led = '0;
		nxt_diag = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				nxt_led.green = 1'b1; // RULE_05
			end
			ST_NO_INPUT: begin
				nxt_led.green = slow_sq; // RULE_13
				nxt_led.yellow = act;
				nxt_diag = act;
			end
			ST_WAIT_FB: begin
				nxt_led.green = 1'b1; // RULE_08
				nxt_led.yellow = marg ? yellow_alt : slow_sq; // RULE_09
				nxt_diag = marg ? fast_sq : 1'b1; // RULE_23
			end
			ST_ACTIVE: begin
				nxt_led.yellow = marg ? slow_sq : 1'b1; // RULE_06
				nxt_led.red = warn_now && fast_sq;
				if (warn_now)
					nxt_diag = 1'b0; // RULE_02
				else
					nxt_diag = marg ? fast_sq : 1'b1; // RULE_07
			end
			ST_ERROR: begin
				nxt_led.red = warn_trip_ff ? fast_sq : red_code; // RULE_10
			end
			ST_TEACH: begin
				nxt_led.red = 1'b1; // RULE_11
				nxt_led.yellow = slow_sq;
			end
			ST_PROTECT: begin
				nxt_led.green = slow_sq; // RULE_12
			end
			default: nxt_led = '0;
		endcase
	end
	// lowest latched cause picks the pulse count, internal is steady
	always_comb begin
		flash_code = 3'h0;
		for (int i = FAULT_W - 1; i >= 0; i--) begin
			if (cause_ff[i])
				flash_code = 3'(i + 1); // RULE_21
		end
		if (INTERNAL_FAULT)
			flash_code = 3'h0;
	end
	// ------------------------------------------------------------
	// sequencing registers
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_ff <= ST_IDLE;
			fb_prev_ff <= 1'b0;
			teach_prev_ff <= 1'b0;
			req_prev_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			fb_prev_ff <= FEEDBACK_IN;
			teach_prev_ff <= TEACH_ACTIVE;
			req_prev_ff <= request_ff[REQ_RESET_BIT];
		end
	end
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			warn_sec_ff <= 12'h0;
			warn_trip_ff <= 1'b0;
		end else if (!warn_now) begin
			warn_sec_ff <= 12'h0; // RULE_03
			warn_trip_ff <= 1'b0;
		end else if (warn_hit) begin
			warn_trip_ff <= 1'b1; // RULE_04
		end else if (sec_tick && !warn_trip_ff) begin
			warn_sec_ff <= warn_sec_ff + 12'h1;
		end
	end
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N)
			prot_sec_ff <= 12'h0;
		else if (state_ff != ST_PROTECT)
			prot_sec_ff <= 12'h0;
		else if (sec_tick)
			prot_sec_ff <= prot_sec_ff + 12'h1;
	end
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			guard_open_ff <= 1'b0;
			cause_ff <= 6'h0;
		end else if (state_ff != ST_ERROR) begin
			guard_open_ff <= 1'b0;
			cause_ff <= FAULT_CAUSE;
		end else begin
			guard_open_ff <= guard_open_ff || !act;
			cause_ff <= cause_ff | FAULT_CAUSE;
		end
	end
	// output faults stick until the outputs are released again
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N)
			out_fault_ff <= 6'h0;
		else if (released)
			out_fault_ff <= FAULT_CAUSE & FAULT_OUT_MASK; // RULE_20
		else
			out_fault_ff <= out_fault_ff | (FAULT_CAUSE & FAULT_OUT_MASK);
	end
	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			safe_ff <= 1'b0;
			led_ff <= '0;
			diag_ff <= 1'b0;
			sdo_ff <= 1'b0;
		end else begin
			if (!hold)
				safe_ff <= nxt_safe; // RULE_16
			led_ff <= nxt_led;
			diag_ff <= !serial_var && nxt_diag;
			sdo_ff <= serial_var && SERIAL_DIAG_IN; // RULE_14
		end
	end
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N)
			resp_ff <= 8'h0;
		else
			resp_ff <= {state_ff == ST_ERROR, warn_now, marg, // RULE_18
				inputs_ok, state_ff == ST_WAIT_FB, 1'b0, act, // RULE_17
				safe_ff};
	end
	assign SAFETY_OUTPUT_ONE = safe_ff;
	assign SAFETY_OUTPUT_TWO = safe_ff;
	assign LED_GREEN = led_ff.green;
	assign LED_RED = led_ff.red;
	assign LED_YELLOW = led_ff.yellow;
	assign DIAG_OUT = diag_ff;
	assign SERIAL_DIAG_OUT = sdo_ff;
	// ------------------------------------------------------------
	// apb slave, zero wait states
	// ------------------------------------------------------------
	wire hit_ctrl = (PADDR == ADDR_CTRL);
	wire hit_req = (PADDR == ADDR_REQUEST);
	wire hit_resp = (PADDR == ADDR_RESPONSE);
	wire hit_diag = (PADDR == ADDR_DIAG);
	wire mapped = hit_ctrl || hit_req || hit_resp || hit_diag;
	wire access = PSEL && PENABLE;
	wire wr_ctrl = access && PWRITE && hit_ctrl;
	wire wr_req = access && PWRITE && hit_req;
	wire [31:0] diag_word = {15'h0, hold, warn_trip_ff, state_ff,
		out_fault_ff, cause_ff};
	assign PREADY = 1'b1;
	assign PSLVERR = access && !mapped;
	assign PRDATA = !(access && !PWRITE) ? 32'h0 :
		hit_ctrl ? {30'h0, ctrl_ff} :
		hit_req ? {24'h0, request_ff} :
		hit_resp ? {24'h0, resp_ff} :
		hit_diag ? diag_word : 32'h0;
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_ff <= CTRL_RESET;
			request_ff <= REQUEST_RESET;
		end else begin
			if (wr_ctrl)
				ctrl_ff <= PWDATA[1:0];
			if (wr_req)
				request_ff <= PWDATA[7:0];
		end
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_error_outputs_off: assert property ( // RULE_01
		@(posedge REF_CLK) disable iff (!RESET_N)
		(state_ff == ST_ERROR && !hold) |-> !SAFETY_OUTPUT_ONE &&
			!SAFETY_OUTPUT_TWO)
		else $error("safety outputs on in error state");
	a_warn_diag_low: assert property ( // RULE_02
		@(posedge REF_CLK) disable iff (!RESET_N)
		(state_ff == ST_ACTIVE && nxt_state == ST_ACTIVE && warn_now &&
			!hold) |=> !DIAG_OUT && SAFETY_OUTPUT_ONE)
		else $error("warning did not drop diagnostic output");
	a_warn_self_clear: assert property ( // RULE_03
		@(posedge REF_CLK) disable iff (!RESET_N)
		!warn_now |=> (warn_sec_ff == 12'h0) && !warn_trip_ff &&
			!resp_ff[RESP_WARN_BIT])
		else $error("warning not cleared with its cause");
	a_warn_trip: assert property ( // RULE_04
		@(posedge REF_CLK) disable iff (!RESET_N)
		warn_hit |=> warn_trip_ff ##1 (state_ff == ST_ERROR) ##1
			!safe_ff || hold)
		else $error("warning timeout did not trip outputs");
	a_idle_green: assert property ( // RULE_05
		@(posedge REF_CLK) disable iff (!RESET_N)
		state_ff == ST_IDLE |=> LED_GREEN && !LED_RED && !LED_YELLOW &&
			!DIAG_OUT)
		else $error("idle indication wrong");
	a_active_yellow: assert property ( // RULE_06
		@(posedge REF_CLK) disable iff (!RESET_N)
		(state_ff == ST_ACTIVE && !marg && !warn_now) |=> LED_YELLOW &&
			!LED_GREEN && !LED_RED && (DIAG_OUT != $past(serial_var)))
		else $error("active indication wrong");
	a_teach_red: assert property ( // RULE_11
		@(posedge REF_CLK) disable iff (!RESET_N)
		state_ff == ST_TEACH |=> LED_RED && !LED_GREEN && !DIAG_OUT)
		else $error("teaching indication wrong");
	a_protect_hold: assert property ( // RULE_12
		@(posedge REF_CLK) disable iff (!RESET_N)
		(state_ff == ST_PROTECT && !hold) |-> !safe_ff && !DIAG_OUT)
		else $error("outputs on during protection time");
	a_leave_zone: assert property ( // RULE_22
		@(posedge REF_CLK) disable iff (!RESET_N)
		(!ACTUATOR_IN_RANGE && !hold) |=> !SAFETY_OUTPUT_ONE)
		else $error("outputs stayed on after actuator left");
	a_resp_bits: assert property ( // RULE_17
		@(posedge REF_CLK) disable iff (!RESET_N)
		1'b1 |=> resp_ff[RESP_SAFE_BIT] == $past(safe_ff) &&
			resp_ff[RESP_INPUTS_BIT] == $past(inputs_ok))
		else $error("response byte does not track state");
	a_hold_freeze: assert property ( // RULE_16
		@(posedge REF_CLK) disable iff (!RESET_N)
		hold |=> $stable(safe_ff))
		else $error("safety outputs moved during link failure");
endmodule : safety_sensor_diag
`default_nettype wire

// >>> safety_sensor_diag_bench.sv
// self-checking bench of the sensor diagnostic block
`timescale 1ns/100ps
`default_nettype none
module safety_sensor_diag_bench;
	import sensor_diag_pkg::*;
	logic clk, rst_n, psel, pen, pwr, prdy, perr, e, p0;
	logic [7:0] paddr;
	logic [31:0] pwd, prd, r;
	logic in1, in2, act, marg, fb, ifl, teach, cfl;
	logic [5:0] fc;
	logic [2:0] wc;
	logic sdi, sent, sdo, dg, so1, so2, lg, lr, ly;
	int fails, checks_done, k, c;
	wire [5:0] pins = {so1, so2, dg, lg, lr, ly};
	safety_sensor_diag #(.TICK_CYC(4), .WARN_S(3), .PROT_S(2)) dut (
		.REF_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd),
		.PREADY(prdy), .PSLVERR(perr), .SAFETY_INPUT_ONE(in1),
		.SAFETY_INPUT_TWO(in2), .ACTUATOR_IN_RANGE(act),
		.ACTUATOR_MARGINAL(marg), .FEEDBACK_IN(fb),
		.INTERNAL_FAULT(ifl), .FAULT_CAUSE(fc), .WARN_CAUSE(wc),
		.TEACH_ACTIVE(teach), .COMM_FAIL(cfl), .SERIAL_DIAG_IN(sdi),
		.SERIAL_DIAG_OUT(sdo), .DIAG_OUT(dg), .SAFETY_OUTPUT_ONE(so1),
		.SAFETY_OUTPUT_TWO(so2), .LED_GREEN(lg), .LED_RED(lr),
		.LED_YELLOW(ly));
	chain_gateway_model #(.CHAIN_POS(1)) gw (.clk(clk), .sdi(sdi),
		.sent_ff(sent));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task tk(input int n);
		repeat (n) @(posedge clk);
	endtask : tk
	task end_of_test;
		if (fails == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, x, s);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		tk(1);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		tk(1);
		pen <= 1'b1;
		n = 0;
		do begin
			tk(1);
			n++;
		end while (prdy !== 1'b1 && n < 16);
		if (n >= 16) begin
			fails++;
			end_of_test;
		end
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk("prdata", r, x);
	endtask : rd
	task tog(input int b, input int n, output int t);
		logic p;
		t = 0;
		repeat (n) begin
			p = pins[b];
			tk(1);
			if (pins[b] !== p) t++;
		end
	endtask : tog
	task guard;
		act <= 1'b0;
		tk(3);
		act <= 1'b1;
		tk(6);
	endtask : guard
	task wait_on;
		c = 0;
		while (so1 !== 1'b1 && c < 400) begin
			tk(1);
			c++;
		end
	endtask : wait_on
	task red_burst(output int t);
		int lo;
		int n;
		lo = 0;
		n = 0;
		t = 0;
		while (lo < 20 && n < 600) begin
			tk(1);
			n++;
			lo = lr ? 0 : lo + 1;
		end
		lo = 0;
		while (lo < 12 && n < 600) begin
			p0 = lr;
			tk(1);
			n++;
			if (lr && !p0) t++;
			lo = lr ? 0 : lo + 1;
		end
		if (n >= 600) begin
			fails++;
			end_of_test;
		end
	endtask : red_burst
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		{psel, pen, pwr, paddr, pwd} = '0;
		{act, marg, fb, ifl, teach, cfl, fc, wc} = '0;
		{in1, in2} = 2'h3;
		rst_n = 1'b0;
		fails = 0;
		checks_done = 0;
		tk(20);
		rst_n <= 1'b1;
		tk(3);
		chk("idle", pins, 6'h04);
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h10);
		rd(8'h20, 32'h0);
		chk("slverr", e, 1'b1);
		act <= 1'b1;
		fb <= 1'b1;
		tk(5);
		chk("active", pins, 6'h39);
		rd(8'h08, 32'h13);
		marg <= 1'b1;
		tk(4);
		rd(8'h08, 32'h33);
		tog(0, 60, k);
		chk("yellow 1hz", k >= 2 && k <= 4, 1'b1);
		tog(3, 20, k);
		chk("diag pulse", k >= 4 && so1, 1'b1);
		marg <= 1'b0;
		wc <= 3'h1;
		tk(4);
		chk("warning", pins[5:3], 3'h6);
		rd(8'h08, 32'h53);
		wc <= 3'h0;
		tk(4);
		chk("warn gone", dg, 1'b1);
		wc <= 3'h4;
		c = 0;
		while (so1 === 1'b1 && c < 400) begin
			tk(1);
			c++;
		end
		chk("trip time", c >= 80 && c <= 200, 1'b1);
		apb(1'b0, 8'h08, 32'h0);
		chk("trip resp", r & 32'h81, 32'h80);
		tog(1, 60, k);
		chk("red flash", k > 0, 1'b1);
		wc <= 3'h0;
		tk(4);
		chk("held", so1, 1'b0);
		guard();
		chk("rearm", so1, 1'b1);
		for (int i = 0; i < 6; i++) begin
			fc <= 6'h01 << i;
			tk(3);
			chk("fault", pins[5:2], 4'h0);
			apb(1'b0, 8'h0c, 32'h0);
			chk("out fault", r[11:6], (i < 3) ? 6'h01 << i : 6'h0);
			red_burst(k);
			chk("pulses", k, i + 1);
			fc <= 6'h00;
			guard();
			chk("cleared", so1, 1'b1);
			apb(1'b0, 8'h0c, 32'h0);
			chk("fault gone", r[11:6], 6'h0);
		end
		ifl <= 1'b1;
		tk(4);
		chk("internal", {so1, lr}, 2'h1);
		tog(1, 40, k);
		chk("red steady", k, 0);
		ifl <= 1'b0;
		guard();
		chk("internal clear", so1, 1'b1);
		act <= 1'b0;
		tk(2);
		chk("leave", so1 | so2, 1'b0);
		in2 <= 1'b0;
		tk(4);
		chk("no input", {pins[5:3], pins[1:0]}, 5'h0);
		tog(2, 60, k);
		chk("green 1hz", k >= 2, 1'b1);
		act <= 1'b1;
		tk(4);
		chk("no input act", {pins[5:3], pins[1:0]}, 5'h05);
		in2 <= 1'b1;
		act <= 1'b0;
		apb(1'b1, 8'h00, 32'h2);
		act <= 1'b1;
		tk(4);
		chk("fb wait", pins[5:2], 4'h3);
		apb(1'b0, 8'h08, 32'h0);
		chk("fb resp", r & 32'h09, 32'h08);
		marg <= 1'b1;
		tk(4);
		tog(0, 80, k);
		chk("alt yellow", k > 6 && !so1, 1'b1);
		marg <= 1'b0;
		fb <= 1'b0;
		tk(4);
		chk("fb edge", so1, 1'b1);
		fb <= 1'b1;
		apb(1'b1, 8'h00, 32'h1);
		tk(4);
		chk("serial", {so1, dg}, 2'h2);
		repeat (8) begin
			tk(1);
			chk("chain", sdo, sent);
		end
		cfl <= 1'b1;
		act <= 1'b0;
		tk(4);
		chk("frozen", so1, 1'b1);
		cfl <= 1'b0;
		tk(3);
		chk("unfrozen", so1, 1'b0);
		act <= 1'b1;
		tk(5);
		fc <= 6'h10;
		tk(3);
		fc <= 6'h00;
		apb(1'b1, 8'h04, 32'h80);
		tk(3);
		chk("no ack", so1, 1'b0);
		apb(1'b1, 8'h04, 32'h0);
		tk(6);
		chk("ack", so1, 1'b1);
		apb(1'b1, 8'h00, 32'h0);
		teach <= 1'b1;
		tk(4);
		chk("teach", pins[5:1], 5'h01);
		teach <= 1'b0;
		wait_on();
		chk("protect", c >= 40 && c <= 200, 1'b1);
		end_of_test;
	end
endmodule : safety_sensor_diag_bench
`default_nettype wire

// >>> sensor_diag_pkg.sv
// shared constants and types of the safety sensor diagnostic block
package sensor_diag_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned FLASH_TICK_MS = 100;
	localparam int unsigned TICK_CYCLES =
		FLASH_TICK_MS * 1_000_000 / CLK_PERIOD_NS;
	localparam int unsigned TICKS_PER_SEC = 1000 / FLASH_TICK_MS;
	localparam int unsigned SLOW_HALF_TICKS = 500 / FLASH_TICK_MS;
	localparam int unsigned FLASH_PAUSE_TICKS = 6;
	localparam int unsigned SEC_PER_MIN = 60;
	localparam int unsigned WARN_DELAY_MIN = 30;
	localparam int unsigned PROTECT_MIN = 10;
	localparam int unsigned WARN_DELAY_S = WARN_DELAY_MIN * SEC_PER_MIN;
	localparam int unsigned PROTECT_S = PROTECT_MIN * SEC_PER_MIN;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_REQUEST = 8'h04;
	localparam logic [7:0] ADDR_RESPONSE = 8'h08;
	localparam logic [7:0] ADDR_DIAG = 8'h0c;
	localparam int unsigned CTRL_SERIAL_BIT = 0;
	localparam int unsigned CTRL_EDGE_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int unsigned REQ_RESET_BIT = 7;
	localparam logic [7:0] REQUEST_RESET = 8'h00;
	localparam int unsigned RESP_SAFE_BIT = 0;
	localparam int unsigned RESP_ACT_BIT = 1;
	localparam int unsigned RESP_FB_OPEN_BIT = 3;
	localparam int unsigned RESP_INPUTS_BIT = 4;
	localparam int unsigned RESP_MARGIN_BIT = 5;
	localparam int unsigned RESP_WARN_BIT = 6;
	localparam int unsigned RESP_ERR_BIT = 7;
	// ------------------------------------------------------------
	// fault causes, bit n gives n+1 red flash pulses
	// ------------------------------------------------------------
	localparam int unsigned FAULT_W = 6;
	localparam logic [5:0] FAULT_OUT_MASK = 6'h07;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_NO_INPUT = 3'b001,
		ST_WAIT_FB = 3'b010,
		ST_ACTIVE = 3'b011,
		ST_ERROR = 3'b100,
		ST_TEACH = 3'b101,
		ST_PROTECT = 3'b110
	} state_type;
	typedef struct packed {
		logic green;
		logic red;
		logic yellow;
	} led_type;
endpackage : sensor_diag_pkg
